// ---- pkg/scl_pkg.sv ----
// constants, frame layout and pin bundle for the serial configuration loader
// assumes one 200 MHz core clock; every pin arrives asynchronously to it
// What this block does
// - sample data-in on serial clock rise, select low
// - sixteen data bits follow eight control and address bits
// - strobe high at select rise: buffer only
// - strobe falling edge applies buffered frame
// - strobe low at select rise: apply directly
// - calibration writes apply at select rise always
// - data-out is last shift register bit
// - both channel enables zero changes nothing
// - calibration-select bit routes write to calibration
// - measure output needs register bit and pin
// - force low-leak when bit or pin low
// - force and measure selectors give six modes
// - shared force and sense switches, own bits
// - four address bits, two channel enables, top ignored
// - control registers take their defaults at power-up
package scl_pkg;

    localparam int FRAME_BITS = 24;
    localparam int DATA_BITS = 16;
    localparam int CLK_PERIOD_NS = 5;
    localparam int SCLK_MIN_PERIOD_NS = 20;
    localparam int SCLK_MIN_PERIOD_CYC = (SCLK_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [3:0] ADDR_DCL_CTRL = 4'h0;
    localparam logic [3:0] ADDR_PMU_CTRL = 4'h8;
    localparam logic [15:0] DCL_CTRL_RESET = 16'h0004;
    localparam logic [15:0] DCL_CAL_RESET = 16'h0008;
    localparam logic [15:0] PMU_CTRL_RESET = 16'h0003;

    // pmu control field positions
    localparam int PMU_FORCE_SEL = 0;
    localparam int PMU_MEASURE_OUTPUT_SEL = 1;
    localparam int PMU_FORCE_EN = 6;
    localparam int PMU_MEASURE_OUTPUT_EN = 7;
    localparam int PMU_EXT_FORCE = 11;
    localparam int PMU_EXT_SENSE = 12;

    typedef struct packed {
        logic top_unused;
        logic calib_select_bit;
        logic chan1_write_en;
        logic chan0_write_en;
        logic [3:0] addr;
        logic [DATA_BITS-1:0] data;
    } scl_frame_t;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic din;
        logic load_n;
        logic rst_n;
        logic measure_output_out_enable_pin;
        logic low_leak_pin_n;
    } scl_pins_t;

    localparam scl_pins_t PINS_IDLE = 7'h7F;

    typedef enum logic [2:0] {
        force_none_measure_none = 3'h0,
        force_none_measure_v = 3'h1,
        force_v_measure_i = 3'h2,
        force_v_measure_v = 3'h3,
        force_i_measure_i = 3'h4,
        force_i_measure_v = 3'h5
    } scl_pmu_mode_t;

endpackage

// ---- hdl/scl_reg_mem.sv ----
// two-channel bank of sixteen 16-bit registers with a registered read port
// assumes writes and the clear come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module scl_reg_mem import scl_pkg::*; #(
    parameter logic [15:0] WORD0_RESET = 16'h0000,
    parameter logic [15:0] WORD8_RESET = 16'h0000
) (
    input wire logic clk,
    input wire logic clear,
    input wire logic [1:0] wr_chan,
    input wire logic [3:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic rd_chan,
    input wire logic [3:0] rd_addr,
    output logic [15:0] rd_data
);
    logic [15:0] mem [0:1][0:15];

    function automatic logic [15:0] reset_word(input int a);
        reset_word = (a == 0) ? WORD0_RESET : ((a == 8) ? WORD8_RESET : 16'h0000);
    endfunction

    always_ff @(posedge clk) begin
        for (int c = 0; c < 2; c++) begin
            for (int a = 0; a < 16; a++) begin
                if (clear) begin
                    mem[c][a] <= reset_word(a);
                end else if (wr_chan[c] && wr_addr == a[3:0]) begin
                    mem[c][a] <= wr_data;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (clear) begin
            rd_data <= 16'h0000;
        end else begin
            rd_data <= mem[rd_chan][rd_addr];
        end
    end
endmodule // scl_reg_mem
`default_nettype wire

// ---- hdl/scl_loader.sv ----
// serial configuration loader: shift register, buffer/update logic and pmu gating
// assumes all pins are asynchronous to CLK; serial clock at most a quarter of CLK
`timescale 1ns/10ps
`default_nettype none
module scl_loader import scl_pkg::*; (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CS_N,
    input wire logic SCLK,
    input wire logic DIN,
    input wire logic LOAD_N,
    input wire logic RST_N,
    input wire logic MEASURE_OUTPUT_OUT_ENABLE_PIN,
    input wire logic LOW_LEAK_PIN_N,
    input wire logic RD_CAL,
    input wire logic RD_CHAN,
    input wire logic [3:0] RD_ADDR,
    output logic DOUT,
    output logic [15:0] RD_DATA,
    output logic [1:0] MEASURE_OUTPUT_EN,
    output logic [1:0] FORCE_OUTPUT_EN,
    output logic [1:0] FORCE_SELECT,
    output logic [1:0] MEASURE_SELECT,
    output scl_pmu_mode_t CH0_MODE,
    output scl_pmu_mode_t CH1_MODE,
    output logic EXT_FORCE_SWITCH_EN,
    output logic EXT_SENSE_SWITCH_EN
);
    // channel write mask; the top address bit takes no part
    function automatic logic [1:0] chan_mask(input scl_frame_t f);
        chan_mask = {f.chan1_write_en, f.chan0_write_en};
    endfunction

    function automatic scl_pmu_mode_t pmu_mode(input logic [15:0] ctrl, input logic lleak_n);
        logic forcing;
        forcing = ctrl[PMU_FORCE_EN] & lleak_n;
        if (!forcing) begin
            pmu_mode = ctrl[PMU_MEASURE_OUTPUT_SEL] ? force_none_measure_v : force_none_measure_none;
        end else if (!ctrl[PMU_FORCE_SEL]) begin
            pmu_mode = ctrl[PMU_MEASURE_OUTPUT_SEL] ? force_v_measure_v : force_v_measure_i;
        end else begin
            pmu_mode = ctrl[PMU_MEASURE_OUTPUT_SEL] ? force_i_measure_v : force_i_measure_i;
        end
    endfunction

    scl_pins_t pins_raw;
    scl_pins_t pins_meta;
    scl_pins_t pins;
    logic sclk_prev;
    logic cs_n_prev;
    logic load_n_prev;
    logic [FRAME_BITS-1:0] shift_reg;
    scl_frame_t buf_frame;
    logic buf_pending;
    logic [15:0] pmu_ctrl [0:1];
    logic [15:0] rd_active;
    logic [15:0] rd_calib;
    logic rd_cal_q;

    assign pins_raw = '{cs_n: CS_N, sclk: SCLK, din: DIN, load_n: LOAD_N, rst_n: RST_N,
                        measure_output_out_enable_pin: MEASURE_OUTPUT_OUT_ENABLE_PIN, low_leak_pin_n: LOW_LEAK_PIN_N};

    // only the second stage feeds any logic
    always_ff @(posedge CLK) begin
        if (RESET) begin
            pins_meta <= PINS_IDLE;
            pins <= PINS_IDLE;
        end else begin
            pins_meta <= pins_raw;
            pins <= pins_meta;
        end
    end

    wire clear_all = RESET | ~pins.rst_n;
    wire sclk_rise = pins.sclk & ~sclk_prev;
    wire cs_rise = pins.cs_n & ~cs_n_prev;
    wire load_fall = ~pins.load_n & load_n_prev;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            sclk_prev <= 1'b1;
            cs_n_prev <= 1'b1;
            load_n_prev <= 1'b1;
        end else begin
            sclk_prev <= pins.sclk;
            cs_n_prev <= pins.cs_n;
            load_n_prev <= pins.load_n;
        end
    end

    // extra clocks push the oldest bits out of data-out; only the last 24 stay
    always_ff @(posedge CLK) begin
        if (clear_all) begin
            shift_reg <= '0;
        end else if (sclk_rise && !pins.cs_n) begin
            shift_reg <= {shift_reg[FRAME_BITS-2:0], pins.din};
        end
    end

    assign DOUT = shift_reg[FRAME_BITS-1];

    // frame decode at the select rising edge
    scl_frame_t frame;
    assign frame = scl_frame_t'(shift_reg);

    wire [1:0] frame_mask = chan_mask(frame);
    wire [1:0] buf_mask = chan_mask(buf_frame);
    wire frame_live = cs_rise && (frame_mask != 2'b00);
    wire calib_write = frame_live && frame.calib_select_bit;
    wire normal_live = frame_live && !frame.calib_select_bit;
    wire direct_write = normal_live && !pins.load_n;
    wire defer_write = normal_live && pins.load_n;
    // a direct frame wins over a buffered apply landing in the same cycle
    wire apply_buf = load_fall && buf_pending && !direct_write;

    wire [1:0] act_wr_chan = direct_write ? frame_mask : (apply_buf ? buf_mask : 2'b00);
    wire [3:0] act_wr_addr = direct_write ? frame.addr : buf_frame.addr;
    wire [15:0] act_wr_data = direct_write ? frame.data : buf_frame.data;
    wire [1:0] cal_wr_chan = calib_write ? frame_mask : 2'b00;

    always_ff @(posedge CLK) begin
        if (clear_all) begin
            buf_frame <= '0;
            buf_pending <= 1'b0;
        end else if (defer_write) begin
            buf_frame <= frame;
            buf_pending <= 1'b1;
        end else if (direct_write) begin
            buf_frame <= frame;
            buf_pending <= 1'b0;
        end else if (apply_buf) begin
            buf_pending <= 1'b0;
        end
    end

    // pmu control is kept in flops too because it steers outputs every cycle
    always_ff @(posedge CLK) begin
        for (int c = 0; c < 2; c++) begin
            if (clear_all) begin
                pmu_ctrl[c] <= PMU_CTRL_RESET;
            end else if (act_wr_chan[c] && act_wr_addr == ADDR_PMU_CTRL) begin
                pmu_ctrl[c] <= act_wr_data;
            end
        end
    end

    scl_reg_mem #(
        .WORD0_RESET(DCL_CTRL_RESET),
        .WORD8_RESET(PMU_CTRL_RESET)
    ) u_active (
        .clk(CLK),
        .clear(clear_all),
        .wr_chan(act_wr_chan),
        .wr_addr(act_wr_addr),
        .wr_data(act_wr_data),
        .rd_chan(RD_CHAN),
        .rd_addr(RD_ADDR),
        .rd_data(rd_active)
    );

    scl_reg_mem #(
        .WORD0_RESET(DCL_CAL_RESET),
        .WORD8_RESET(16'h0000)
    ) u_calib (
        .clk(CLK),
        .clear(clear_all),
        .wr_chan(cal_wr_chan),
        .wr_addr(frame.addr),
        .wr_data(frame.data),
        .rd_chan(RD_CHAN),
        .rd_addr(RD_ADDR),
        .rd_data(rd_calib)
    );

    always_ff @(posedge CLK) begin
        if (RESET) begin
            rd_cal_q <= 1'b0;
        end else begin
            rd_cal_q <= RD_CAL;
        end
    end

    assign RD_DATA = rd_cal_q ? rd_calib : rd_active;

    // pmu gating, registered so the outputs come straight from flops
    wire [1:0] next_measure_output_en = {pmu_ctrl[1][PMU_MEASURE_OUTPUT_EN], pmu_ctrl[0][PMU_MEASURE_OUTPUT_EN]}
                              & {2{pins.measure_output_out_enable_pin}};
    wire [1:0] next_force_en = {pmu_ctrl[1][PMU_FORCE_EN], pmu_ctrl[0][PMU_FORCE_EN]}
                               & {2{pins.low_leak_pin_n}};
    wire [1:0] next_force_sel = {pmu_ctrl[1][PMU_FORCE_SEL], pmu_ctrl[0][PMU_FORCE_SEL]};
    wire [1:0] next_measure_output_sel = {pmu_ctrl[1][PMU_MEASURE_OUTPUT_SEL], pmu_ctrl[0][PMU_MEASURE_OUTPUT_SEL]};
    scl_pmu_mode_t next_mode0;
    scl_pmu_mode_t next_mode1;
    assign next_mode0 = pmu_mode(pmu_ctrl[0], pins.low_leak_pin_n);
    assign next_mode1 = pmu_mode(pmu_ctrl[1], pins.low_leak_pin_n);
    // switches are shared: either channel closing its bit closes the switch
    wire next_ext_force = pmu_ctrl[0][PMU_EXT_FORCE] | pmu_ctrl[1][PMU_EXT_FORCE];
    wire next_ext_sense = pmu_ctrl[0][PMU_EXT_SENSE] | pmu_ctrl[1][PMU_EXT_SENSE];

    always_ff @(posedge CLK) begin
        if (RESET) begin
            MEASURE_OUTPUT_EN <= 2'h0;
            FORCE_OUTPUT_EN <= 2'h0;
            FORCE_SELECT <= 2'h3;
            MEASURE_SELECT <= 2'h3;
            CH0_MODE <= force_none_measure_v;
            CH1_MODE <= force_none_measure_v;
            EXT_FORCE_SWITCH_EN <= 1'b0;
            EXT_SENSE_SWITCH_EN <= 1'b0;
        end else begin
            MEASURE_OUTPUT_EN <= next_measure_output_en;
            FORCE_OUTPUT_EN <= next_force_en;
            FORCE_SELECT <= next_force_sel;
            MEASURE_SELECT <= next_measure_output_sel;
            CH0_MODE <= next_mode0;
            CH1_MODE <= next_mode1;
            EXT_FORCE_SWITCH_EN <= next_ext_force;
            EXT_SENSE_SWITCH_EN <= next_ext_sense;
        end
    end
endmodule // scl_loader
`default_nettype wire

// ---- sim/scl_host_model.sv ----
// host model driving the serial link, capturing data-out
// assumes the bench calls send and moves load_n between frames
`timescale 1ns/10ps
`default_nettype none
module scl_host_model (
    input wire logic clk,
    input wire logic dout,
    output logic cs_n,
    output logic sclk,
    output logic din,
    output logic load_n
);
    int hp = 16;
    logic [31:0] rx = 32'h0;
    initial begin
        cs_n = 1'h1;
        sclk = 1'h0;
        din = 1'h0;
        load_n = 1'h1;
    end
    // hp of 2 is the fastest legal link
    task automatic half();
        repeat (hp) @(negedge clk);
    endtask
    // the bench moves the strobe and the rate only through these, so each has one writer
    task automatic set_load(input logic v);
        load_n = v;
    endtask
    task automatic set_half(input int n);
        hp = n;
    endtask
    // link clock pulses with select high; the loader must ignore them
    task automatic stray(input int n);
        for (int i = 0; i < n; i++) begin
            half();
            sclk = 1'h1;
            half();
            sclk = 1'h0;
        end
    endtask
    // top bit first, data moves only while the link clock is low
    task automatic send(input int n, input logic [31:0] v);
        cs_n = 1'h0;
        for (int i = n - 1; i >= 0; i--) begin
            din = v[i];
            half();
            rx = {rx[30:0], dout};
            sclk = 1'h1;
            half();
            sclk = 1'h0;
        end
        half();
        cs_n = 1'h1;
        // released line inverts so a stale bit cannot pass
        din = ~din;
        half();
    endtask
endmodule // scl_host_model
`default_nettype wire

// ---- sim/scl_loader_assertions.sv ----
// pin-level checks of the loader, bound to its top module
// assumes RESET is synchronous to CLK
`timescale 1ns/10ps
`default_nettype none
module scl_loader_assertions import scl_pkg::*; (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CS_N,
    input wire logic LOAD_N,
    input wire logic RST_N,
    input wire logic MEASURE_OUTPUT_OUT_ENABLE_PIN,
    input wire logic LOW_LEAK_PIN_N,
    input wire logic DOUT,
    input wire logic [1:0] MEASURE_OUTPUT_EN,
    input wire logic [1:0] FORCE_OUTPUT_EN,
    input wire logic [1:0] FORCE_SELECT,
    input wire logic [1:0] MEASURE_SELECT,
    input wire scl_pmu_mode_t CH0_MODE,
    input wire scl_pmu_mode_t CH1_MODE,
    input wire logic EXT_FORCE_SWITCH_EN
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    a_measure_output_gate: assert property (!MEASURE_OUTPUT_OUT_ENABLE_PIN [*4] |=> MEASURE_OUTPUT_EN == 2'h0)
        else $error("measure output on with pin low");
    a_force_gate: assert property (!LOW_LEAK_PIN_N [*4] |=> FORCE_OUTPUT_EN == 2'h0)
        else $error("force output on with low-leak pin low");
    a_dout_idle: assert property ((CS_N && RST_N) [*8] |=> $stable(DOUT))
        else $error("data-out moved while deselected");
    a_ch0_mode: assert property (CH0_MODE == (FORCE_OUTPUT_EN[0] ?
        {FORCE_SELECT[0], !FORCE_SELECT[0], MEASURE_SELECT[0]} : {2'h0, MEASURE_SELECT[0]}))
        else $error("channel 0 mode wrong");
    a_ch1_mode: assert property (CH1_MODE == (FORCE_OUTPUT_EN[1] ?
        {FORCE_SELECT[1], !FORCE_SELECT[1], MEASURE_SELECT[1]} : {2'h0, MEASURE_SELECT[1]}))
        else $error("channel 1 mode wrong");
    a_reset_state: assert property (disable iff (1'h0) RESET [*2] |=> FORCE_SELECT == 2'h3
        && MEASURE_OUTPUT_EN == 2'h0 && FORCE_OUTPUT_EN == 2'h0) else $error("reset state wrong");
    a_quiet_hold: assert property ((CS_N && LOAD_N && RST_N) [*8] |=>
        $stable({FORCE_SELECT, MEASURE_SELECT, EXT_FORCE_SWITCH_EN})) else $error("control moved while idle");
    a_pin_reset: assert property (!RST_N [*6] |=> FORCE_SELECT == 2'h3 && MEASURE_SELECT == 2'h3
        && !EXT_FORCE_SWITCH_EN) else $error("reset pin left control set");
endmodule // scl_loader_assertions
bind scl_loader scl_loader_assertions u_chk (
    .CLK(CLK),
    .RESET(RESET),
    .CS_N(CS_N),
    .LOAD_N(LOAD_N),
    .RST_N(RST_N),
    .MEASURE_OUTPUT_OUT_ENABLE_PIN(MEASURE_OUTPUT_OUT_ENABLE_PIN),
    .LOW_LEAK_PIN_N(LOW_LEAK_PIN_N),
    .DOUT(DOUT),
    .MEASURE_OUTPUT_EN(MEASURE_OUTPUT_EN),
    .FORCE_OUTPUT_EN(FORCE_OUTPUT_EN),
    .FORCE_SELECT(FORCE_SELECT),
    .MEASURE_SELECT(MEASURE_SELECT),
    .CH0_MODE(CH0_MODE),
    .CH1_MODE(CH1_MODE),
    .EXT_FORCE_SWITCH_EN(EXT_FORCE_SWITCH_EN)
);
`default_nettype wire

// ---- sim/tb_scl_loader.sv ----
// self-checking bench for the serial configuration loader
// assumes the host model drives the link at CLK falling edges
`timescale 1ns/10ps
`default_nettype none
module tb_scl_loader import scl_pkg::*;;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic rst_n = 1'h1;
    logic measure_output_pin = 1'h1;
    logic leak_pin_n = 1'h1;
    logic [1:0] rd_sel = 2'h0;
    logic [3:0] rd_addr = 4'h0;
    wire logic cs_n, sclk, din, load_n, dout, ext_force, ext_sense;
    wire logic [15:0] rd_data;
    wire logic [1:0] measure_output_en, force_en, force_sel, measure_output_sel;
    wire scl_pmu_mode_t ch0_mode, ch1_mode;
    int mismatches = 0;
    int samples_checked = 0;
    logic [2:0] modes [6] = '{3'h2, 3'h4, 3'h3, 3'h5, 3'h1, 3'h0};
    logic [15:0] codes [6] = '{16'h00C0, 16'h00C1, 16'h00C2, 16'h00C3, 16'h0002, 16'h0000};

    scl_loader DUT (.CLK(clk), .RESET(reset), .CS_N(cs_n), .SCLK(sclk), .DIN(din), .LOAD_N(load_n),
        .RST_N(rst_n), .MEASURE_OUTPUT_OUT_ENABLE_PIN(measure_output_pin), .LOW_LEAK_PIN_N(leak_pin_n), .RD_CAL(rd_sel[1]),
        .RD_CHAN(rd_sel[0]), .RD_ADDR(rd_addr), .DOUT(dout), .RD_DATA(rd_data), .MEASURE_OUTPUT_EN(measure_output_en),
        .FORCE_OUTPUT_EN(force_en), .FORCE_SELECT(force_sel), .MEASURE_SELECT(measure_output_sel), .CH0_MODE(ch0_mode),
        .CH1_MODE(ch1_mode), .EXT_FORCE_SWITCH_EN(ext_force), .EXT_SENSE_SWITCH_EN(ext_sense));
    scl_host_model host (.clk(clk), .dout(dout), .cs_n(cs_n), .sclk(sclk), .din(din), .load_n(load_n));

    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic rd(input logic [1:0] sel, input logic [3:0] a, input logic [15:0] exp);
        cyc(8);
        rd_sel = sel;
        rd_addr = a;
        cyc(2);
        check(rd_data, exp);
    endtask
    // top bit set on purpose; the eight bits above the frame stay zero
    function automatic logic [31:0] fr(input logic cal, input logic [1:0] en, input logic [3:0] a,
        input logic [15:0] d);
        return {8'h0, 1'h1, cal, en, a, d};
    endfunction
    task automatic wr(input logic ld, input logic [31:0] f);
        @(negedge clk);
        host.set_load(ld);
        host.send(24, f);
    endtask
    task automatic summarize();
        if (mismatches == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (40000) @(negedge clk);
        mismatches++;
        summarize();
    end

    initial begin
        cyc(5);
        reset = 1'h0;
        rd(2'h0, 4'h0, 16'h0004);
        rd(2'h1, 4'h8, 16'h0003);
        rd(2'h2, 4'h0, 16'h0008);
        check({measure_output_en, force_en, force_sel}, 6'h03);
        wr(1'h0, fr(1'h0, 2'h1, 4'h8, 16'h18C0));
        check({ch0_mode, ch1_mode, measure_output_en, force_en, ext_force, ext_sense}, 12'h457);
        for (int i = 0; i < 6; i++) begin
            wr(1'h0, fr(1'h0, 2'h2, 4'h8, codes[i]));
            check({ch1_mode, force_sel[1], measure_output_sel[1]}, {modes[i], codes[i][0], codes[i][1]});
        end
        measure_output_pin = 1'h0;
        cyc(6);
        check(measure_output_en, 2'h0);
        measure_output_pin = 1'h1;
        leak_pin_n = 1'h0;
        cyc(6);
        check({force_en, ch0_mode}, 5'h00);
        leak_pin_n = 1'h1;
        wr(1'h1, fr(1'h0, 2'h1, 4'h1, 16'h1234));
        rd(2'h0, 4'h1, 16'h0000);
        host.set_load(1'h0);
        rd(2'h0, 4'h1, 16'h1234);
        wr(1'h1, fr(1'h1, 2'h1, 4'h1, 16'hABCD));
        rd(2'h2, 4'h1, 16'hABCD);
        rd(2'h0, 4'h1, 16'h1234);
        wr(1'h0, fr(1'h0, 2'h0, 4'h1, 16'hFFFF));
        check(host.rx[23:0], fr(1'h1, 2'h1, 4'h1, 16'hABCD));
        rd(2'h0, 4'h1, 16'h1234);
        host.send(28, fr(1'h0, 2'h3, 4'h2, 16'h5A5A) | 32'h0F000000);
        check(host.rx[27:0], (fr(1'h0, 2'h0, 4'h1, 16'hFFFF) << 4) | 32'h0000000F);
        rd(2'h0, 4'h2, 16'h5A5A);
        rd(2'h1, 4'h2, 16'h5A5A);
        // a frame with no channel enabled must not clobber a pending buffer
        wr(1'h1, fr(1'h0, 2'h1, 4'h4, 16'h0044));
        wr(1'h1, fr(1'h0, 2'h0, 4'h4, 16'h0099));
        host.set_load(1'h0);
        rd(2'h0, 4'h4, 16'h0044);
        host.set_half(2);
        wr(1'h0, fr(1'h0, 2'h1, 4'h3, 16'h0F0F));
        host.set_half(16);
        rd(2'h0, 4'h3, 16'h0F0F);
        // link clock pulses while deselected must not shift
        host.stray(4);
        check(dout, 1'h1);
        rst_n = 1'h0;
        cyc(8);
        rst_n = 1'h1;
        rd(2'h1, 4'h8, 16'h0003);
        rd(2'h0, 4'h1, 16'h0000);
        summarize();
    end
endmodule // tb_scl_loader
`default_nettype wire
